// ### logic/tcc_pkg.sv
package tcc_pkg;
   // Register addresses on the special function register port.
   localparam logic [7:0] ADDR_CTRL = 8'hc8;
   localparam logic [7:0] ADDR_RLD_LO = 8'hca;
   localparam logic [7:0] ADDR_RLD_HI = 8'hcb;
   localparam logic [7:0] ADDR_CNT_LO = 8'hcc;
   localparam logic [7:0] ADDR_CNT_HI = 8'hcd;
   localparam logic [7:0] ADDR_CLK_CTRL = 8'hce;
   // Field positions in the control register.
   localparam int HI_FLAG_BIT = 7;
   localparam int LO_FLAG_BIT = 6;
   localparam int LO_INT_EN_BIT = 5;
   localparam int CAP_EN_BIT = 4;
   localparam int SPLIT_BIT = 3;
   localparam int RUN_BIT = 2;
   localparam int XCLK_BIT = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hfd;
   // Field positions in the clock control register.
   localparam int HI_SEL_BIT = 5;
   localparam int LO_SEL_BIT = 4;
   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] RLD_RESET = 16'h0000;
   // Prescaler for the divided system clock.
   localparam int PRESCALE = 12;
   localparam logic [3:0] PRE_LAST = 4'(PRESCALE - 1);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      logic ext_lvl;
      logic [3:0] pre;
      logic [7:0] ctrl;
      logic hi_sel;
      logic lo_sel;
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [7:0] rdata;
   } tcc_state_t;
endpackage

// ### logic/tcc_timer.sv
`timescale 1ns/100ps
module tcc_timer
   import tcc_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ext_clk_div8,
   input wire logic timer_int_enable,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   output logic timer_irq
);

   tcc_state_t st_r;
   tcc_state_t st_nxt;
   logic cap_stb;
   logic tick12;
   logic lo_tick;
   logic hi_tick;
   logic cap_on;
   logic set_hi;
   logic set_lo;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   // Picks one byte's count clock from its select bits.
   function automatic logic sel_tick(input logic fast, input logic xclk,
         input logic t12, input logic text);
      sel_tick = fast | (xclk ? text : t12);
   endfunction

   // The filtered level falls once the last two stages agree low.
   assign cap_stb = st_r.ext_lvl & ~st_r.sync2 & ~st_r.sync3;
   assign tick12 = (st_r.pre == PRE_LAST);
   assign cap_on = st_r.ctrl[CAP_EN_BIT];

   always_comb begin
      if (cap_on) begin
         lo_tick = st_r.lo_sel | tick12;
         hi_tick = st_r.lo_sel | tick12;
      end else begin
         lo_tick = sel_tick(st_r.lo_sel, st_r.ctrl[XCLK_BIT], tick12,
            cap_stb);
         hi_tick = sel_tick(st_r.hi_sel, st_r.ctrl[XCLK_BIT], tick12,
            cap_stb);
      end
   end

   always_comb begin
      st_nxt = st_r;
      set_hi = 1'b0;
      set_lo = 1'b0;
      st_nxt.sync1 = ext_clk_div8;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sync3 = st_r.sync2;
      if (st_r.sync2 == st_r.sync3) begin
         st_nxt.ext_lvl = st_r.sync3;
      end
      st_nxt.pre = tick12 ? 4'h0 : st_r.pre + 4'h1;
      if (!st_r.ctrl[SPLIT_BIT]) begin
         if (st_r.ctrl[RUN_BIT] && lo_tick) begin
            if (st_r.cnt == 16'hffff) begin
               st_nxt.cnt = st_r.rld;
               set_hi = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt + 16'h0001;
            end
            if (st_r.cnt[7:0] == 8'hff) begin
               set_lo = 1'b1;
            end
         end
      end else begin
         if (lo_tick) begin
            if (st_r.cnt[7:0] == 8'hff) begin
               st_nxt.cnt[7:0] = st_r.rld[7:0];
               set_lo = 1'b1;
            end else begin
               st_nxt.cnt[7:0] = st_r.cnt[7:0] + 8'h01;
            end
         end
         if (st_r.ctrl[RUN_BIT] && hi_tick) begin
            if (st_r.cnt[15:8] == 8'hff) begin
               st_nxt.cnt[15:8] = st_r.rld[15:8];
               set_hi = 1'b1;
            end else begin
               st_nxt.cnt[15:8] = st_r.cnt[15:8] + 8'h01;
            end
         end
      end
      if (sfr_wr) begin
         case (sfr_addr)
            ADDR_CTRL: st_nxt.ctrl = sfr_wdata & CTRL_WMASK;
            ADDR_RLD_LO: st_nxt.rld[7:0] = sfr_wdata;
            ADDR_RLD_HI: st_nxt.rld[15:8] = sfr_wdata;
            ADDR_CNT_LO: st_nxt.cnt[7:0] = sfr_wdata;
            ADDR_CNT_HI: st_nxt.cnt[15:8] = sfr_wdata;
            ADDR_CLK_CTRL: begin
               st_nxt.hi_sel = sfr_wdata[HI_SEL_BIT];
               st_nxt.lo_sel = sfr_wdata[LO_SEL_BIT];
            end
            default: st_nxt.rld = st_nxt.rld;
         endcase
      end
      // A capture outranks a software write to the reload bytes.
      if (cap_on && cap_stb) begin
         st_nxt.rld = st_r.cnt;
         set_hi = 1'b1;
      end
      // Hardware sets win over a software clear in the same cycle.
      if (set_hi) begin
         st_nxt.ctrl[HI_FLAG_BIT] = 1'b1;
      end
      if (set_lo) begin
         st_nxt.ctrl[LO_FLAG_BIT] = 1'b1;
      end
      if (sfr_rd) begin
         case (sfr_addr)
            ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
            ADDR_RLD_LO: st_nxt.rdata = st_r.rld[7:0];
            ADDR_RLD_HI: st_nxt.rdata = st_r.rld[15:8];
            ADDR_CNT_LO: st_nxt.rdata = st_r.cnt[7:0];
            ADDR_CNT_HI: st_nxt.rdata = st_r.cnt[15:8];
            ADDR_CLK_CTRL: begin
               st_nxt.rdata = 8'h00;
               st_nxt.rdata[HI_SEL_BIT] = st_r.hi_sel;
               st_nxt.rdata[LO_SEL_BIT] = st_r.lo_sel;
            end
            default: st_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '{sync1: 1'b0, sync2: 1'b0, sync3: 1'b0, ext_lvl: 1'b0,
            pre: 4'h0, ctrl: CTRL_RESET, hi_sel: 1'b0, lo_sel: 1'b0,
            cnt: CNT_RESET, rld: RLD_RESET, rdata: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sfr_rdata = st_r.rdata;
   assign timer_irq = timer_int_enable & (st_r.ctrl[HI_FLAG_BIT] |
      (st_r.ctrl[LO_INT_EN_BIT] & st_r.ctrl[LO_FLAG_BIT]));

   sequence s_capture;
      cap_on && cap_stb;
   endsequence

   sequence s_no_ctrl_write;
      !(sfr_wr && sfr_addr == ADDR_CTRL);
   endsequence

   a_capture_copy: assert property (
      s_capture |=> st_r.rld == $past(st_r.cnt))
      else $error("Capture did not copy the count into reload.");

   a_capture_flag: assert property (
      s_capture |=> st_r.ctrl[HI_FLAG_BIT])
      else $error("Capture did not set the high flag.");

   a_strobe_single: assert property (
      cap_stb |=> !cap_stb ##1 !cap_stb)
      else $error("Capture strobe lasted more than one cycle.");

   a_fall_edge: assert property (
      cap_stb |-> ($past(st_r.sync3) && !st_r.sync3) ##1 !st_r.ext_lvl)
      else $error("Capture strobe without a falling external clock.");

   a_wide_roll: assert property (
      !st_r.ctrl[SPLIT_BIT] && st_r.ctrl[RUN_BIT] && lo_tick &&
      st_r.cnt == 16'hffff && !sfr_wr |=>
         st_r.ctrl[HI_FLAG_BIT] && st_r.cnt == $past(st_r.rld))
      else $error("16-bit rollover missed reload or high flag.");

   a_low_roll: assert property (
      st_r.ctrl[SPLIT_BIT] && lo_tick && st_r.cnt[7:0] == 8'hff |=>
         st_r.ctrl[LO_FLAG_BIT])
      else $error("Low byte rollover did not set the low flag.");

   a_flags_sticky: assert property (
      st_r.ctrl[HI_FLAG_BIT] ##0 s_no_ctrl_write |=>
         st_r.ctrl[HI_FLAG_BIT])
      else $error("High flag cleared without a software write.");

   a_irq_high: assert property (
      timer_int_enable && st_r.ctrl[HI_FLAG_BIT] |-> timer_irq)
      else $error("High flag with interrupt enabled gave no request.");

   a_irq_low: assert property (
      timer_irq |-> timer_int_enable && (st_r.ctrl[HI_FLAG_BIT] ||
         st_r.ctrl[LO_INT_EN_BIT] && st_r.ctrl[LO_FLAG_BIT]))
      else $error("Interrupt request without an enabled flag.");

   a_div12_rate: assert property (
      tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12 ##1 !tick12
         ##1 tick12)
      else $error("Divided clock tick is not every twelve cycles.");

   a_fast_count: assert property (
      !st_r.ctrl[SPLIT_BIT] && st_r.ctrl[RUN_BIT] && cap_on &&
      st_r.lo_sel && st_r.cnt != 16'hffff && !sfr_wr |=>
         st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("Fast capture mode did not count every cycle.");

endmodule

// ### testbench/tcc_ext_osc.sv
`timescale 1ns/100ps
// Divided external oscillator; it holds its level while run is low.
module tcc_ext_osc (
   input wire logic clock,
   input wire logic run,
   input wire logic [9:0] half,
   output logic ext_clk
);
   initial ext_clk = 1'b1;
   // Each phase lasts half clocks, one or more for any nonzero half.
   always begin
      @(posedge clock);
      if (run) begin
         repeat (half - 1) @(posedge clock);
         #1 ext_clk = ~ext_clk;
      end
   end
endmodule

// ### testbench/tb_timer_capture_control.sv
`timescale 1ns/100ps
module tb_timer_capture_control;
   import tcc_pkg::*;
   logic clock = 0;
   logic arst_n = 0;
   logic ext_clk_div8;
   logic timer_int_enable = 0;
   logic [7:0] sfr_addr = 0;
   logic [7:0] sfr_wdata = 0;
   logic sfr_wr = 0;
   logic sfr_rd = 0;
   logic [7:0] sfr_rdata;
   logic timer_irq;
   logic osc_run = 0;
   logic [9:0] half = 10'd40;
   logic [7:0] v;
   logic [7:0] h;
   logic [15:0] c1;
   logic [15:0] c2;
   int fails = 0;
   int n_checks = 0;
   always #2.5 clock = ~clock;
   tcc_timer uut (.clock(clock), .arst_n(arst_n),
      .ext_clk_div8(ext_clk_div8), .timer_int_enable(timer_int_enable),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer_irq(timer_irq));
   tcc_ext_osc osc (.clock(clock), .run(osc_run), .half(half),
      .ext_clk(ext_clk_div8));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Each access ends with one idle cycle before the next strobe.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_wr = 1;
      sfr_addr = a;
      sfr_wdata = d;
      @(posedge clock);
      #1 sfr_wr = 0;
      @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_rd = 1;
      sfr_addr = a;
      @(posedge clock);
      #1 sfr_rd = 0;
      d = sfr_rdata;
      @(posedge clock);
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Clears the high flag, waits for the next capture, reads the reload.
   task automatic cap(output logic [15:0] c);
      wr(ADDR_CTRL, 8'h14);
      v = 8'h00;
      for (int i = 0; i < 400 && v[HI_FLAG_BIT] !== 1'b1; i++) begin
         rd(ADDR_CTRL, v);
      end
      if (v[HI_FLAG_BIT] !== 1'b1) begin
         fails++;
         give_verdict;
      end else begin
         rd(ADDR_RLD_LO, v);
         rd(ADDR_RLD_HI, h);
         c = {h, v};
      end
   endtask
   initial begin
      repeat (12) @(posedge clock);
      #1 arst_n = 1;
      rd(ADDR_CTRL, v);
      chk(v, CTRL_RESET);
      wr(8'hc0, 8'hff);
      rd(8'hc0, v);
      chk(v, 8'h00);
      timer_int_enable = 1;
      wr(ADDR_CTRL, 8'hff);
      rd(ADDR_CTRL, v);
      chk(v, 8'hfd);
      chk(timer_irq, 1'b1);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CTRL, v);
      chk(v, 8'h00);
      chk(timer_irq, 1'b0);
      wr(ADDR_CLK_CTRL, 8'hff);
      rd(ADDR_CLK_CTRL, v);
      chk(v, 8'h30);
      $display("register test done");
      wr(ADDR_RLD_LO, 8'h34);
      wr(ADDR_RLD_HI, 8'h12);
      wr(ADDR_CNT_LO, 8'hf0);
      wr(ADDR_CNT_HI, 8'hff);
      wr(ADDR_CTRL, 8'h04);
      cyc(20);
      rd(ADDR_CTRL, v);
      chk(v, 8'hc4);
      rd(ADDR_CNT_HI, v);
      chk(v, 8'h12);
      chk(timer_irq, 1'b1);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_LO, 8'hf0);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CTRL, 8'h24);
      cyc(20);
      rd(ADDR_CTRL, v);
      chk(v, 8'h64);
      chk(timer_irq, 1'b1);
      wr(ADDR_CTRL, 8'h40);
      chk(timer_irq, 1'b0);
      $display("overflow test done");
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      osc_run = 1;
      // A fast timer clock against the capture clock.
      cap(c1);
      cap(c2);
      chk(c2 - c1, 16'h0050);
      wr(ADDR_CTRL, 8'h04);
      cyc(200);
      rd(ADDR_CTRL, v);
      chk(v[HI_FLAG_BIT], 1'b0);
      wr(ADDR_CLK_CTRL, 8'h00);
      half = 10'd120;
      cap(c1);
      cap(c2);
      chk(c2 - c1, 16'h0014);
      $display("capture test done");
      // Three falls of the divided clock in a window of 720 cycles.
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CTRL, 8'h05);
      cyc(719);
      rd(ADDR_CNT_LO, v);
      chk(v, 8'h03);
      // Split mode: the low byte runs alone and wraps.
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_RLD_LO, 8'h80);
      wr(ADDR_CNT_LO, 8'hf0);
      wr(ADDR_CLK_CTRL, 8'h10);
      wr(ADDR_CTRL, 8'h08);
      cyc(20);
      rd(ADDR_CTRL, v);
      chk(v, 8'h48);
      rd(ADDR_CNT_HI, v);
      chk(v, 8'h00);
      $display("mode test done");
      give_verdict;
   end
endmodule
